// >>> inc/hsl_pkg.sv
`default_nettype none
// shared constants and state layout for the horizontal sync lock and drive block
package hsl_pkg;
  // clock rate
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;

  // counter width for line timing
  localparam int unsigned CNT_W = 16;

  // free-run span: 0.8 to 1.3 times nominal, held as tenths
  localparam int unsigned FR_LOW_X10  = 8;
  localparam int unsigned FR_HIGH_X10 = 13;

  // forced frequency multiples
  localparam int unsigned FORCE_2X = 2;
  localparam int unsigned FORCE_3X = 3;

  // duty span: 30 to 60 percent, as 1/256 fractions
  localparam logic [8:0] DUTY_MIN_Q8  = 9'h04D;
  localparam logic [8:0] DUTY_SPAN_Q8 = 9'h04D;

  // phase span: full code swing covers one tenth of the line either way
  localparam logic [7:0]  PHASE_CENTER = 8'h80;
  localparam int unsigned PHASE_DIV    = 1280;

  // settings after power-on
  localparam logic [7:0] FREE_RUN_RESET = 8'hFF;
  localparam logic [7:0] DUTY_RESET     = 8'hFF;

  // lock detector
  localparam logic [3:0]  LOCK_HITS     = 4'h8;
  localparam int unsigned WINDOW_SHIFT  = 4;
  localparam int unsigned GAIN_CATCH_SH = 2;
  localparam int unsigned GAIN_HOLD_SH  = 6;

  // serial control address bytes
  localparam logic [7:0] ADDR_WRITE = 8'h8C;
  localparam logic [7:0] ADDR_READ  = 8'h8D;

  // forced frequency selector codes
  localparam logic [1:0] FORCE_OFF = 2'h0;
  localparam logic [1:0] FORCE_X2  = 2'h1;
  localparam logic [1:0] FORCE_X3  = 2'h2;

  // complete block state
  typedef struct packed {
    logic [2:0]       hs_sync;
    logic [1:0]       fb_sync;
    logic [1:0]       xr_sync;
    logic [1:0]       lv_sync;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] pull;
    logic [CNT_W-1:0] since;
    logic [CNT_W-1:0] run_hi;
    logic [CNT_W-1:0] run_lo;
    logic [CNT_W-1:0] last_hi;
    logic [CNT_W-1:0] act_run;
    logic             pol;
    logic             vert;
    logic             locked;
    logic [3:0]       hits;
    logic             xray;
    logic             drive;
    logic             lock_out;
    logic             status;
    logic             regen;
    logic             addr_ack;
    logic             addr_rd;
  } hsl_state_t;

  localparam hsl_state_t STATE_RESET = '{hs_sync: 3'h7, status: 1'b1, default: '0}; // sync pipe at pulled-up idle
endpackage : hsl_pkg
`default_nettype wire

// >>> src/hsl_drive.sv
`default_nettype none
// Contract
// R1 - lock pin high, status bit low together
// R2 - controller steps free-run down until locked
// R3 - either polarity, narrow pulses, leading edge sync
// R4 - wide pulses above quarter line mark vertical
// R5 - edges too early in line are dropped
// R6 - phase-frequency loop, large gain unlocked, small locked
// R7 - no loop correction during extracted vertical
// R8 - free-run 0.8 to 1.3, reset at 1.3
// R9 - sync always faster than free-run
// R10 - forced 2x/3x opens loop, fixed period
// R11 - phase reference shift plus/minus tenth line
// R12 - lock checked continuously, dropped on loss
// R13 - lock state available in read status
// R14 - drive duty 30 to 60, reset 60
// R15 - drive off: low supply, xray, flyback, disabled
// R16 - drive switch off while scan transistor off
// R17 - xray input inhibits drive and regulator
// R18 - xray latched, cleared by supply loss or command
// R19 - answer address bytes 8C write, 8D read
// R20 - lock after run of edges inside window
module hsl_drive #(
  parameter int unsigned NOM_PERIOD = 6400
) (
  // clock and reset
  input  wire  logic       ref_clk_i,
  input  wire  logic       reset_i,
  // pins
  input  wire  logic       hsync_composite_in,
  input  wire  logic       flyback_i,
  input  wire  logic       xray_i,
  input  wire  logic       supply_low_i,
  // control settings
  input  wire  logic [7:0] free_run_set_i,
  input  wire  logic [7:0] duty_set_i,
  input  wire  logic [7:0] phase_set_i,
  input  wire  logic [1:0] force_sel_i,
  input  wire  logic       drive_enable_i,
  input  wire  logic       xray_reset_i,
  // address byte check
  input  wire  logic [7:0] addr_byte_i,
  input  wire  logic       addr_valid_i,
  // outputs
  output logic             hdrive_o,
  output logic             lock_o,
  output logic             lock_status_bit_o,
  output logic             xray_status_o,
  output logic             regulator_enable_o,
  output logic             vsync_extract_o,
  output logic             sync_polarity_o,
  output logic             addr_match_o,
  output logic             addr_read_o
);

  // line periods in clock cycles
  localparam int unsigned P_SLOW = NOM_PERIOD * 10 / hsl_pkg::FR_LOW_X10;
  localparam int unsigned P_FAST = NOM_PERIOD * 10 / hsl_pkg::FR_HIGH_X10;
  localparam int unsigned P_2X   = NOM_PERIOD / hsl_pkg::FORCE_2X;
  localparam int unsigned P_3X   = NOM_PERIOD / hsl_pkg::FORCE_3X;
  localparam int unsigned W      = hsl_pkg::CNT_W;

  hsl_pkg::hsl_state_t st_q;
  hsl_pkg::hsl_state_t st_d;

  // next-state logic
  always_comb begin
    logic [31:0] fr_span;
    logic [31:0] free_per;
    logic [31:0] per;
    logic [31:0] duty_q8;
    logic [31:0] on_cyc;
    logic signed [33:0] ofs;
    logic signed [33:0] ref_pt;
    logic signed [33:0] err;
    logic signed [33:0] abs_err;
    logic signed [33:0] step;
    logic signed [33:0] pull_new;
    logic signed [33:0] pull_max;
    logic signed [33:0] ph_diff;
    logic signed [33:0] cnt_adj;
    logic        raw;
    logic        raw_d;
    logic        s_now;
    logic        s_old;
    logic        lead;
    logic        accept;
    logic        hit;
    logic        forced;
    logic        xr;
    logic        lv;
    logic        fb;
    fr_span  = 32'(P_SLOW - P_FAST);
    free_per = '0;
    per      = '0;
    duty_q8  = '0;
    on_cyc   = '0;
    ofs      = '0;
    ref_pt   = '0;
    err      = '0;
    abs_err  = '0;
    step     = '0;
    pull_new = '0;
    pull_max = '0;
    ph_diff  = '0;
    cnt_adj  = '0;
    raw      = 1'b0;
    raw_d    = 1'b0;
    s_now    = 1'b0;
    s_old    = 1'b0;
    lead     = 1'b0;
    accept   = 1'b0;
    hit      = 1'b0;
    forced   = 1'b0;
    xr       = 1'b0;
    lv       = 1'b0;
    fb       = 1'b0;
    st_d     = st_q;

    // pin synchronisers
    st_d.hs_sync = {st_q.hs_sync[1:0], hsync_composite_in};
    st_d.fb_sync = {st_q.fb_sync[0], flyback_i};
    st_d.xr_sync = {st_q.xr_sync[0], xray_i};
    st_d.lv_sync = {st_q.lv_sync[0], supply_low_i};
    // second and third flops give the edge pair
    raw   = st_q.hs_sync[1];
    raw_d = st_q.hs_sync[2];
    fb    = st_q.fb_sync[1];
    xr    = st_q.xr_sync[1];
    lv    = st_q.lv_sync[1];

    // free-run period, top code is the fast end
    free_per = 32'(P_FAST) + ((fr_span * {24'h0000_00, 8'hFF - free_run_set_i}) >> 8); // R8
    // the loop may shorten the line by up to three quarters
    pull_max = 34'(free_per - (free_per >> 2));

    // forced multiples hold a fixed period
    case (force_sel_i)
      hsl_pkg::FORCE_X2: begin
        forced = 1'b1;
        per    = 32'(P_2X); // R10
      end
      hsl_pkg::FORCE_X3: begin
        forced = 1'b1;
        per    = 32'(P_3X); // R10
      end
      default: begin
        forced = 1'b0;
        per    = free_per - {16'h0000, st_q.pull};
      end
    endcase

    // line oscillator
    if (32'(st_q.cnt) >= per - 32'h0000_0001) begin
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end

    // polarity from high and low run lengths
    if (raw) begin
      st_d.run_hi = (st_q.run_hi == '1) ? st_q.run_hi : st_q.run_hi + 1'b1;
    end else begin
      st_d.run_lo = (st_q.run_lo == '1) ? st_q.run_lo : st_q.run_lo + 1'b1;
    end
    // run lengths latched at each pin edge
    if (raw && !raw_d) begin
      st_d.pol    = (st_q.last_hi > st_q.run_lo); // R3
      st_d.run_lo = '0;
    end
    if (!raw && raw_d) begin
      st_d.last_hi = st_q.run_hi;
      st_d.run_hi  = '0;
    end

    // internal sync, active high whatever the input polarity
    s_now = raw ^ st_q.pol; // R3
    s_old = raw_d ^ st_q.pol;
    lead  = s_now && !s_old; // R3

    // wide pulse integration extracts vertical
    if (s_now) begin
      st_d.act_run = (st_q.act_run == '1) ? st_q.act_run : st_q.act_run + 1'b1;
    end else begin
      st_d.act_run = '0;
    end
    // a level held for many lines is an idle or stuck pin, not a vertical pulse
    st_d.vert = s_now && (32'(st_q.act_run) > (per >> 2)) // R4
                && (32'(st_q.act_run) < (per << 3));

    // time since last accepted edge
    st_d.since = (st_q.since == '1) ? st_q.since : st_q.since + 1'b1;
    // edges too soon after the last one are equalizing pulses
    accept = lead && (32'(st_q.since) >= ((per * 32'h0000_0003) >> 2)); // R5
    if (accept) begin
      st_d.since = '0;
    end

    // phase reference with offset
    // signed so that codes below centre move the reference earlier
    ph_diff = signed'(34'(phase_set_i)) - signed'(34'(hsl_pkg::PHASE_CENTER));
    ofs    = (signed'(34'(per)) * ph_diff) / signed'(34'(hsl_pkg::PHASE_DIV)); // R11
    ref_pt = 34'(per >> 1) + ofs; // R11
    err    = 34'(st_q.cnt) - ref_pt;
    // window test on the magnitude of the phase error
    abs_err = (err < 0) ? -err : err;
    hit    = abs_err < 34'(per >> hsl_pkg::WINDOW_SHIFT); // R20

    // lock detector
    if (accept) begin
      if (hit) begin
        st_d.hits = (st_q.hits == hsl_pkg::LOCK_HITS) ? st_q.hits : st_q.hits + 1'b1; // R20
      end else begin
        st_d.hits = '0; // R12
      end
    end
    // no accepted edge for two lines drops lock
    if (32'(st_q.since) > (per << 1)) begin
      st_d.hits = '0; // R12
    end
    // locked once the run of hits is complete
    st_d.locked = (st_d.hits == hsl_pkg::LOCK_HITS); // R12

    // loop correction, gain chosen by lock state
    if (st_q.locked) begin
      step = err >>> hsl_pkg::GAIN_HOLD_SH; // R6
    end else begin
      step = err >>> hsl_pkg::GAIN_CATCH_SH; // R6
    end
    // integral path: the pull sets the line period
    pull_new = 34'(st_q.pull) - step;
    // clamp keeps the period inside the loop range
    if (pull_new < 0) begin
      pull_new = '0;
    end else if (pull_new > pull_max) begin
      pull_new = pull_max;
    end
    // proportional path: move the ramp part of the way toward the reference,
    // which damps the loop so that it settles instead of ringing
    cnt_adj = 34'(st_q.cnt) + 34'h0_0000_0001 - step;
    if (cnt_adj >= 34'(per)) begin
      cnt_adj = '0;
    end
    if (accept && !st_q.vert && !forced) begin // R7
      st_d.pull = pull_new[W-1:0]; // R6
      st_d.cnt  = cnt_adj[W-1:0]; // R6
    end

    // forced multiples open the loop and park the pull
    if (forced) begin
      st_d.pull = '0; // R10
    end

    // xray latch, set wins over clear
    st_d.xray = xr || (st_q.xray && !xray_reset_i && !lv); // R18

    // drive shaping and inhibits
    duty_q8 = 32'(hsl_pkg::DUTY_MIN_Q8) + ((32'(hsl_pkg::DUTY_SPAN_Q8) * {24'h0000_00, duty_set_i}) >> 8); // R14
    // on time as a fraction of the current line
    on_cyc  = (per * duty_q8) >> 8; // R14
    st_d.drive = (32'(st_q.cnt) < on_cyc) // R16
                 && drive_enable_i && !lv && !fb // R15
                 && !xr && !st_q.xray; // R17

    // regulator enable shares the xray inhibit
    st_d.regen = !xr && !st_q.xray && !lv; // R17

    // lock reporting
    st_d.lock_out = st_d.locked; // R1
    st_d.status   = !st_d.locked; // R13

    // address byte recognition
    if (addr_valid_i) begin
      st_d.addr_ack = (addr_byte_i == hsl_pkg::ADDR_WRITE) || (addr_byte_i == hsl_pkg::ADDR_READ); // R19
      st_d.addr_rd  = (addr_byte_i == hsl_pkg::ADDR_READ); // R19
    end else begin
      st_d.addr_ack = 1'b0;
      st_d.addr_rd  = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_q <= hsl_pkg::STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state
  assign hdrive_o           = st_q.drive;
  assign lock_o             = st_q.lock_out; // R1
  assign lock_status_bit_o  = st_q.status; // R1
  assign xray_status_o      = st_q.xray;
  assign regulator_enable_o = st_q.regen;
  assign vsync_extract_o    = st_q.vert;
  assign sync_polarity_o    = st_q.pol;
  assign addr_match_o       = st_q.addr_ack;
  assign addr_read_o        = st_q.addr_rd;

endmodule // hsl_drive
`default_nettype wire

// >>> test/hsl_drive_chk.sv
`default_nettype none
// port-level checks of the sync lock and drive block
module hsl_drive_chk #(
  parameter int unsigned NOM_PERIOD = 6400
) (
  input wire logic       ref_clk_i, reset_i, flyback_i, xray_i, supply_low_i,
  input wire logic       drive_enable_i, xray_reset_i, addr_valid_i,
  input wire logic [7:0] addr_byte_i,
  input wire logic       hdrive_o, lock_o, lock_status_bit_o, xray_status_o,
  input wire logic       regulator_enable_o, addr_match_o, addr_read_o, vsync_extract_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // address byte is one of the two answered values
  wire logic addr_hit = addr_byte_i == hsl_pkg::ADDR_WRITE || addr_byte_i == hsl_pkg::ADDR_READ;

  a_lock_pin_bit:
    assert property (lock_o != lock_status_bit_o) else $error("lock pin and bit agree");
  a_addr_match:
    assert property (addr_valid_i && addr_hit |=> addr_match_o && addr_read_o == $past(addr_byte_i[0]))
      else $error("address byte not answered");
  a_addr_idle:
    assert property (!(addr_valid_i && addr_hit) |=> !addr_match_o) else $error("stray address match");
  a_xray_block:
    assert property (xray_i [*3] |=> xray_status_o && !hdrive_o && !regulator_enable_o)
      else $error("xray did not inhibit");
  a_xray_hold:
    assert property ((!supply_low_i) [*3] ##0 (xray_status_o && !xray_reset_i) |=> xray_status_o)
      else $error("xray latch lost");
  a_xray_clear:
    assert property ((!xray_i) [*3] ##0 xray_reset_i |=> !xray_status_o) else $error("xray latch not cleared");
  a_flyback_blank:
    assert property (flyback_i [*3] |=> !hdrive_o) else $error("drive during flyback");
  a_supply_blank:
    assert property (supply_low_i [*3] |=> !hdrive_o && !regulator_enable_o) else $error("drive at low supply");
  a_enable_blank:
    assert property (!drive_enable_i |=> !hdrive_o) else $error("drive while disabled");

  c_lock: cover property ($rose(lock_o));
  c_vert: cover property ($rose(vsync_extract_o));
  c_xray: cover property ($rose(xray_status_o));
endmodule // hsl_drive_chk

bind hsl_drive hsl_drive_chk #(.NOM_PERIOD(NOM_PERIOD)) u_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .flyback_i(flyback_i), .xray_i(xray_i),
  .supply_low_i(supply_low_i), .drive_enable_i(drive_enable_i), .xray_reset_i(xray_reset_i),
  .addr_valid_i(addr_valid_i), .addr_byte_i(addr_byte_i), .hdrive_o(hdrive_o), .lock_o(lock_o),
  .lock_status_bit_o(lock_status_bit_o), .xray_status_o(xray_status_o), .regulator_enable_o(regulator_enable_o),
  .addr_match_o(addr_match_o), .addr_read_o(addr_read_o), .vsync_extract_o(vsync_extract_o)
);
`default_nettype wire

// >>> test/hsl_sync_src.sv
`default_nettype none
// sync source: line pulses, optional half-line extras, pulled up when off
module hsl_sync_src (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic        neg_i,
  input  wire logic        eq_i,
  input  wire logic [15:0] per_i,
  input  wire logic [15:0] wid_i,
  output var  logic        sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pos_q;
  // line counter, period kept shorter than free-run by the bench
  always @(posedge clk_i) begin
    pos_q <= (en_i && pos_q + 16'h0001 < per_i) ? pos_q + 16'h0001 : 16'h0000;
    sync_o <= !en_i || (neg_i ^ (pos_q < wid_i || (eq_i && pos_q >= per_i / 2 && pos_q < per_i / 2 + wid_i)));
  end
endmodule // hsl_sync_src
`default_nettype wire

// >>> test/hsl_drive_tb_top.sv
`default_nettype none
// self-checking bench for the sync lock and drive block
module hsl_drive_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, reset_i, flyback_i, xray_i, supply_low_i, drive_enable_i, xray_reset_i, addr_valid_i;
  logic [7:0]  free_run_set_i, duty_set_i, phase_set_i, addr_byte_i, b;
  logic [1:0]  force_sel_i;
  logic        hdrive_o, lock_o, lock_status_bit_o, xray_status_o, regulator_enable_o, vsync_extract_o;
  logic        sync_polarity_o, addr_match_o, addr_read_o, hsync, en, neg, eq, sh, sv;
  logic [15:0] per, wid;
  logic        exp_q[$];
  logic [2:0]  blank [3] = '{3'b110, 3'b000, 3'b011};
  int          tbl [5][5] = '{'{1, 255, 255, 100, 60}, '{2, 255, 255, 66, 60}, '{3, 255, 255, 153, 60},
                              '{0, 0, 255, 250, 60}, '{0, 255, 0, 153, 30}};
  int          fails, num_checks, seed, hi, pr;

  hsl_drive #(.NOM_PERIOD(200)) dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsync_composite_in(hsync), .flyback_i(flyback_i),
    .xray_i(xray_i), .supply_low_i(supply_low_i), .free_run_set_i(free_run_set_i), .duty_set_i(duty_set_i),
    .phase_set_i(phase_set_i), .force_sel_i(force_sel_i), .drive_enable_i(drive_enable_i),
    .xray_reset_i(xray_reset_i), .addr_byte_i(addr_byte_i), .addr_valid_i(addr_valid_i), .hdrive_o(hdrive_o),
    .lock_o(lock_o), .lock_status_bit_o(lock_status_bit_o), .xray_status_o(xray_status_o),
    .regulator_enable_o(regulator_enable_o), .vsync_extract_o(vsync_extract_o),
    .sync_polarity_o(sync_polarity_o), .addr_match_o(addr_match_o), .addr_read_o(addr_read_o)
  );
  hsl_sync_src u_src (.clk_i(ref_clk_i), .en_i(en), .neg_i(neg), .eq_i(eq), .per_i(per), .wid_i(wid), .sync_o(hsync));

  // 200 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = !ref_clk_i;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got, input int tol);
    num_checks++;
    if ((^got === 1'bx) || got + tol < exp || got > exp + tol) begin
      fails++;
      $display("wrong value %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // collect drive and vertical activity over n cycles
  task automatic watch(input int n);
    {sh, sv} = 2'b00;
    repeat (n) begin
      @(negedge ref_clk_i);
      sh |= hdrive_o;
      sv |= vsync_extract_o;
    end
  endtask

  // one full drive period: high time and length
  task automatic measure();
    hi = 0;
    for (int g = 0; g < 999 && hdrive_o !== 1'b0; g++) @(negedge ref_clk_i);
    for (int g = 0; g < 999 && hdrive_o !== 1'b1; g++) @(negedge ref_clk_i);
    for (; hi < 999 && hdrive_o === 1'b1; hi++) @(negedge ref_clk_i);
    for (pr = hi; pr < 999 && hdrive_o !== 1'b1; pr++) @(negedge ref_clk_i);
  endtask

  // address answers compared with the oldest note
  always @(negedge ref_clk_i) begin
    if (addr_match_o === 1'b1 && exp_q.size() == 0) chk("stray match", 0, 1, 0);
    else if (addr_match_o === 1'b1) chk("read flag", exp_q.pop_front(), addr_read_o, 0);
  end

  // watchdog
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    fails++;
    complete_run();
  end

  initial begin
    {reset_i, drive_enable_i, neg} = 3'b111;
    {flyback_i, xray_i, supply_low_i, xray_reset_i, addr_valid_i, en, eq, force_sel_i} = '0;
    {free_run_set_i, duty_set_i, phase_set_i, addr_byte_i} = 32'hFFFF_8000;
    {per, wid} = 32'h008C_000E;
    seed = 5668;
    repeat (19) @(negedge ref_clk_i);
    chk("reset outputs", 16'h0008, {lock_o, lock_status_bit_o, hdrive_o, xray_status_o, regulator_enable_o}, 0);
    @(posedge ref_clk_i);
    reset_i <= 1'b0;
    for (int k = 0; k < 24; k++) begin
      @(posedge ref_clk_i);
      b = (k % 4 == 0) ? 8'h8C + 8'(k / 4 % 2) : 8'($random(seed));
      {addr_valid_i, addr_byte_i} <= {1'b1, b};
      if (b == 8'h8C || b == 8'h8D) exp_q.push_back(b == 8'h8D);
    end
    @(posedge ref_clk_i);
    addr_valid_i <= 1'b0;
    watch(3);
    chk("notes left", 0, 16'(exp_q.size()), 0);
    $display("address test done");
    foreach (tbl[i]) begin
      @(posedge ref_clk_i);
      {force_sel_i, free_run_set_i, duty_set_i} <= {2'(tbl[i][0]), 8'(tbl[i][1]), 8'(tbl[i][2])};
      watch(600);
      measure();
      chk("line period", 16'(tbl[i][3]), 16'(pr), 2);
      chk("duty percent", 16'(tbl[i][4]), 16'(pr > 0 ? hi * 100 / pr : 0), 2);
    end
    foreach (blank[k]) begin
      @(posedge ref_clk_i);
      {flyback_i, drive_enable_i, supply_low_i} <= blank[k];
      watch(4);
      watch(300);
      chk("blanked drive", 0, sh, 0);
      @(posedge ref_clk_i);
      {flyback_i, drive_enable_i, supply_low_i} <= 3'b010;
    end
    $display("drive test done");
    en <= 1'b1;
    for (int k = 0; k < 4 && lock_o !== 1'b1; k++) begin
      @(posedge ref_clk_i);
      free_run_set_i <= 8'hFF - 8'(k * 16);
      for (int g = 0; g < 6000 && lock_o !== 1'b1; g++) @(negedge ref_clk_i);
    end
    chk("lock pin", 1, lock_o, 0);
    chk("lock bit", 0, lock_status_bit_o, 0);
    chk("negative sync", 1, sync_polarity_o, 0);
    @(posedge ref_clk_i);
    eq <= 1'b1;
    watch(2800);
    chk("lock with extras", 1, lock_o, 0);
    @(posedge ref_clk_i);
    {eq, neg} <= 2'b00;
    watch(1400);
    chk("positive sync", 0, sync_polarity_o, 0);
    @(posedge ref_clk_i);
    {neg, wid} <= {1'b1, 16'h0031};
    watch(700);
    chk("vertical found", 1, sv, 0);
    @(posedge ref_clk_i);
    wid <= 16'h000E;
    watch(300);
    watch(700);
    chk("no vertical", 0, sv, 0);
    @(posedge ref_clk_i);
    en <= 1'b0;
    watch(700);
    chk("lock lost", 0, lock_o, 0);
    chk("unlock bit", 1, lock_status_bit_o, 0);
    $display("lock test done");
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_i);
      xray_i <= 1'b1;
      watch(5);
      @(posedge ref_clk_i);
      xray_i <= 1'b0;
      watch(300);
      chk("xray latched", 1, xray_status_o, 0);
      chk("xray drive", 0, {sh, regulator_enable_o}, 0);
      @(posedge ref_clk_i);
      {xray_reset_i, supply_low_i} <= k ? 2'b01 : 2'b10;
      watch(6);
      @(posedge ref_clk_i);
      {xray_reset_i, supply_low_i} <= 2'b00;
      watch(6);
      chk("xray cleared", 0, xray_status_o, 0);
    end
    $display("xray test done");
    complete_run();
  end
endmodule // hsl_drive_tb_top
`default_nettype wire
